// >>> qdf_frame_decoder.sv
`timescale 1ns/100ps
`include "qdf_regs.svh"
// Summary of operation
// - one command is exactly 24 bits
// - bits arrive msb first
// - top bit chooses read or write
// - select 0..3: dac, range, power, control
// - address 0..3 channel, 4 all
// - select 0 writes addressed channel codes
// - codes left justified, low bits dropped
// - every register writable; reads return dac channel codes only
module qdf_frame_decoder
  import qdf_pkg::*;
(
  input  wire logic        core_clk_i,     // 200 MHz core clock
  input  wire logic        rst_n_i,        // sync reset, active low
  input  wire logic        sclk_i,         // link clock
  input  wire logic        frame_n_i,      // frame, active low
  input  wire logic        sdi_i,          // serial_data_input
  input  wire logic [1:0]  res_i,          // resolution variant
  output logic [63:0]      code_o,         // four channel codes, a low
  output logic [2:0]       other_sel_o,    // select of other register
  output logic [2:0]       other_addr_o,   // its address field
  output logic [15:0]      other_data_o,   // its payload field
  output logic             other_wr_o,     // pulse: other reg write
  output logic             rd_req_o,       // pulse: read requested
  output logic [15:0]      rd_data_o,      // read data, dac selects
  output logic             zero_err_o      // sticky: reserved bit set
);
  qdf_cmd_t   link_word;
  logic       link_tgl;
  logic       tgl_s1_q;
  logic       tgl_s2_q;
  logic       tgl_s3_q;
  logic       frm_s1_q;
  logic       frm_s2_q;
  qdf_state_t st_q;
  qdf_state_t st_d;
  qdf_cmd_t   cmd_q;
  qdf_cmd_t   cmd_d;
  logic [15:0] code_q [4];
  logic [15:0] code_d [4];
  logic [15:0] rdd_q;
  logic [15:0] rdd_d;
  logic       owr_q;
  logic       owr_d;
  logic       rdr_q;
  logic       rdr_d;
  logic       zerr_q;
  logic       zerr_d;
  logic       word_evt;
  logic [3:0] ch_sel;

  // link side assembly in its own clock domain
  qdf_shift u_shift (
    .sclk_i    (sclk_i),
    .rst_n_i   (rst_n_i),
    .frame_n_i (frame_n_i),
    .sdi_i     (sdi_i),
    .word_o    (link_word),
    .tgl_o     (link_tgl)
  );

  // channel decode, shared by write and read paths
  function automatic logic [3:0] ch_mask(input logic [2:0] a);
    case (a)
      `QDF_CH_A:   ch_mask = 4'h1;
      `QDF_CH_B:   ch_mask = 4'h2;
      `QDF_CH_C:   ch_mask = 4'h4;
      `QDF_CH_D:   ch_mask = 4'h8;
      `QDF_CH_ALL: ch_mask = 4'hf;
      default:     ch_mask = 4'h0;  // undefined codes touch nothing
    endcase
  endfunction : ch_mask

  // left justified code with ignored low bits cleared
  function automatic logic [15:0] justify(input logic [15:0] d,
                                          input logic [1:0]  r);
    case (r)
      `QDF_RES_14: justify = {d[15:2], 2'h0};
      `QDF_RES_12: justify = {d[15:4], 4'h0};
      default:     justify = d;
    endcase
  endfunction : justify

  // toggle and frame level sync; stage one only feeds stage two
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      frm_s1_q <= 1'b1;
      frm_s2_q <= 1'b1;
    end else begin
      tgl_s1_q <= link_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      frm_s1_q <= frame_n_i;
      frm_s2_q <= frm_s1_q;
    end
  end

  assign word_evt = tgl_s2_q ^ tgl_s3_q;

  // channel mask of the held command: one-hot for a..d, all four for broadcast
  assign ch_sel = ch_mask(cmd_q.addr);

  // wait for complete word, then frame end, then execute
  always_comb begin
    st_d   = st_q;
    cmd_d  = cmd_q;
    code_d = code_q;
    rdd_d  = rdd_q;
    owr_d  = 1'b0;
    rdr_d  = 1'b0;
    zerr_d = zerr_q;
    case (st_q)
      QDF_IDLE: begin
        if (word_evt) begin
          cmd_d = link_word;  // stable: held since toggle flipped
          st_d  = QDF_SYNC;
        end
      end
      QDF_SYNC: begin
        if (frm_s2_q) begin
          st_d = QDF_EXEC;
        end
      end
      QDF_EXEC: begin
        st_d = QDF_IDLE;
        if (cmd_q.zero) begin
          zerr_d = 1'b1;  // flagged, command still obeyed
        end
        if (cmd_q.rd) begin
          rdr_d = 1'b1;
          for (int i = 0; i < 4; i++) begin
            if (ch_sel == 4'(1 << i)) begin
              rdd_d = code_q[i];
            end
          end
        end else if (cmd_q.sel == `QDF_SEL_DAC) begin
          for (int i = 0; i < 4; i++) begin
            if (ch_sel[i]) begin
              code_d[i] = justify(cmd_q.data, res_i);
            end
          end
        end else begin
          owr_d = 1'b1;  // range, power, control go outward
        end
      end
      default: st_d = QDF_IDLE;
    endcase
  end

  // register stage
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q   <= QDF_IDLE;
      cmd_q  <= qdf_cmd_t'(`QDF_WORD_RST);
      for (int i = 0; i < 4; i++) begin
        code_q[i] <= `QDF_CODE_RST;
      end
      rdd_q  <= `QDF_CODE_RST;
      owr_q  <= 1'b0;
      rdr_q  <= 1'b0;
      zerr_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      code_q <= code_d;
      rdd_q  <= rdd_d;
      owr_q  <= owr_d;
      rdr_q  <= rdr_d;
      zerr_q <= zerr_d;
    end
  end

  assign code_o       = {code_q[3], code_q[2], code_q[1], code_q[0]};
  assign other_sel_o  = cmd_q.sel;
  assign other_addr_o = cmd_q.addr;
  assign other_data_o = cmd_q.data;
  assign other_wr_o   = owr_q;
  assign rd_req_o     = rdr_q;
  assign rd_data_o    = rdd_q;
  assign zero_err_o   = zerr_q;

  // codes change only in the execute state after frame end
  AST_NO_PARTIAL: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (code_o != $past(code_o)) |-> $past(st_q) == QDF_EXEC)
    else $error("code changed outside execute");

  // write of channel A lands justified
  AST_WRITE_A: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (st_q == QDF_EXEC && !cmd_q.rd && cmd_q.sel == `QDF_SEL_DAC
     && cmd_q.addr == `QDF_CH_A)
    |=> code_o[15:0] == justify($past(cmd_q.data), $past(res_i)))
    else $error("channel A code not written");

  // broadcast writes every channel alike
  AST_ALL_CH: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (st_q == QDF_EXEC && !cmd_q.rd && cmd_q.sel == `QDF_SEL_DAC
     && cmd_q.addr == `QDF_CH_ALL)
    |=> code_o[63:48] == code_o[15:0] && code_o[47:32] == code_o[15:0]
        && code_o[31:16] == code_o[15:0])
    else $error("broadcast write not uniform");

  // reads never alter codes and raise one request pulse
  AST_READ: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (st_q == QDF_EXEC && cmd_q.rd)
    |=> rd_req_o && $stable(code_o) ##1 !rd_req_o)
    else $error("read misbehaved");

  // low bits ignored in 12-bit variant, when channel a is written
  AST_JUSTIFY: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (st_q == QDF_EXEC && !cmd_q.rd && cmd_q.sel == `QDF_SEL_DAC
     && ch_sel[0] && res_i == `QDF_RES_12)
    |=> code_o[3:0] == 4'h0)
    else $error("12-bit low bits kept");

  // non-dac selects pass outward, not into codes
  AST_OTHER: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (st_q == QDF_EXEC && !cmd_q.rd && cmd_q.sel != `QDF_SEL_DAC)
    |=> other_wr_o && $stable(code_o))
    else $error("other select mishandled");

  // execute only while frame has ended
  AST_FRAME_END: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (st_q == QDF_EXEC) |-> $past(frm_s2_q))
    else $error("executed inside frame");

  // payload passes to other registers intact
  AST_PAYLOAD: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    other_wr_o |-> $past(st_q) == QDF_EXEC
                   && other_sel_o != `QDF_SEL_DAC
                   && other_data_o == $past(cmd_q.data))
    else $error("payload altered");
endmodule : qdf_frame_decoder

// >>> qdf_host_model.sv
`timescale 1ns/100ps
// host serial port: frames one word msb first on the link
module qdf_host_model (
  output logic sclk_o,     // link clock, still outside frames
  output logic frame_n_o,  // frame, active low
  output logic sdi_o       // serial data
);
  // idle link: clock parked low; frame raised once reset is under way
  initial begin
    sclk_o    = 1'b0;
    sdi_o     = 1'b0;
    #2 frame_n_o = 1'b1;
  end

  // fewer than 24 bits makes a deliberately short frame
  task automatic send(input logic [23:0] word, input int nbits);
    frame_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi_o = word[23 - i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    #7.5 frame_n_o = 1'b1;
    sdi_o = ~sdi_o;  // released line shows no stale bit
  endtask : send
endmodule : qdf_host_model

// >>> qdf_pkg.sv
package qdf_pkg;
  // one decoded command word
  typedef struct packed {
    logic        rd;     // 1 = read, 0 = write
    logic        zero;   // reserved position
    logic [2:0]  sel;    // register select
    logic [2:0]  addr;   // channel address
    logic [15:0] data;   // payload
  } qdf_cmd_t;

  typedef enum logic [1:0] {
    QDF_IDLE = 2'b00,
    QDF_SYNC = 2'b01,
    QDF_EXEC = 2'b10
  } qdf_state_t;
endpackage : qdf_pkg

// >>> qdf_regs.svh
`ifndef QDF_REGS_SVH
`define QDF_REGS_SVH
// command word layout
`define QDF_WORD_BITS     24
`define QDF_RW_POS        23
`define QDF_ZERO_POS      22
`define QDF_REG_MSB       21
`define QDF_REG_LSB       19
`define QDF_ADDR_MSB      18
`define QDF_ADDR_LSB      16
`define QDF_DATA_MSB      15
`define QDF_DATA_LSB      0
// register select codes
`define QDF_SEL_DAC       3'h0
`define QDF_SEL_RANGE     3'h1
`define QDF_SEL_POWER     3'h2
`define QDF_SEL_CTRL      3'h3
// channel address codes
`define QDF_CH_A          3'h0
`define QDF_CH_B          3'h1
`define QDF_CH_C          3'h2
`define QDF_CH_D          3'h3
`define QDF_CH_ALL        3'h4
// resolution variants and reset values
`define QDF_RES_16        2'h0
`define QDF_RES_14        2'h1
`define QDF_RES_12        2'h2
`define QDF_CODE_RST      16'h0000
`define QDF_WORD_RST      24'h000000
`define QDF_CNT_RST       5'h00
`endif

// >>> qdf_shift.sv
`timescale 1ns/100ps
`include "qdf_regs.svh"
// link-clock side: assembles the word, hands it over by toggle
module qdf_shift
  import qdf_pkg::*;
(
  input  wire logic        sclk_i,      // link clock
  input  wire logic        rst_n_i,     // core reset, async in this domain
  input  wire logic        frame_n_i,   // low while frame active
  input  wire logic        sdi_i,       // serial data input
  output qdf_cmd_t         word_o,      // last complete word
  output logic             tgl_o        // toggles per complete word
);
  logic [23:0] sr_q;
  logic [23:0] sr_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  qdf_cmd_t    word_q;
  qdf_cmd_t    word_d;
  logic        tgl_q;
  logic        tgl_d;
  logic        cnt_clr;

  // msb first shift; counter restarts each frame via the frame pin
  always_comb begin
    sr_d   = {sr_q[22:0], sdi_i};
    cnt_d  = cnt_q;
    word_d = word_q;
    tgl_d  = tgl_q;
    if (!frame_n_i) begin
      if (cnt_q == 5'(`QDF_WORD_BITS - 1)) begin
        word_d = qdf_cmd_t'({sr_q[22:0], sdi_i});
        tgl_d  = ~tgl_q;
      end
      // extra bits past 24 are not counted: word stands at 24th edge
      if (cnt_q != 5'(`QDF_WORD_BITS)) begin
        cnt_d = cnt_q + 5'h01;
      end
    end else begin
      cnt_d = `QDF_CNT_RST;
    end
  end

  // a stopped link clock needs an async clear to rearm the counter
  assign cnt_clr = frame_n_i | ~rst_n_i;

  always_ff @(posedge sclk_i or posedge cnt_clr) begin
    if (cnt_clr) begin
      cnt_q <= `QDF_CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // toggle must start at the core sync reset level, else a false word
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_q <= qdf_cmd_t'(`QDF_WORD_RST);
      tgl_q  <= 1'b0;
    end else begin
      word_q <= word_d;
      tgl_q  <= tgl_d;
    end
  end

  // shift stage needs no reset: only complete words leave it
  always_ff @(posedge sclk_i) begin
    sr_q <= sr_d;
  end

  assign word_o = word_q;
  assign tgl_o  = tgl_q;
endmodule : qdf_shift

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  import qdf_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i;
  logic [1:0]  res_i      = 2'h0;
  logic        sclk, frame_n, sdi, other_wr_o, rd_req_o, zero_err_o;
  logic [63:0] code_o;
  logic [2:0]  other_sel_o, other_addr_o;
  logic [15:0] other_data_o, rd_data_o;
  logic [15:0] exp_code [4];
  logic [31:0] r;
  int err_count = 0, total_checks = 0, seed = 64;
  int wr_cnt = 0, rd_cnt = 0, exp_wr = 0, exp_rd = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  qdf_host_model u_qdf_host_model (.sclk_o(sclk), .frame_n_o(frame_n),
    .sdi_o(sdi));

  qdf_frame_decoder u_qdf_frame_decoder (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .sclk_i(sclk), .frame_n_i(frame_n), .sdi_i(sdi),
    .res_i(res_i), .code_o(code_o), .other_sel_o(other_sel_o),
    .other_addr_o(other_addr_o), .other_data_o(other_data_o),
    .other_wr_o(other_wr_o), .rd_req_o(rd_req_o), .rd_data_o(rd_data_o),
    .zero_err_o(zero_err_o));

  // pulses counted mid-cycle, away from the launching edge
  always @(negedge core_clk_i) begin
    if (other_wr_o === 1'b1) wr_cnt++;
    if (rd_req_o === 1'b1) rd_cnt++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // unused low bits of narrower variants read back as zero
  function automatic logic [15:0] trim(logic [15:0] d, logic [1:0] v);
    case (v)
      2'h1:    return d & 16'hfffc;
      2'h2:    return d & 16'hfff0;
      default: return d;
    endcase
  endfunction : trim

  // one frame, then wait well past the execute latency and compare
  task automatic cmd(input logic rd, input logic z, input logic [2:0] sel,
                     input logic [2:0] addr, input logic [15:0] data,
                     input int n);
    qdf_cmd_t    c;
    logic [63:0] exp_all;
    c = '{rd, z, sel, addr, data};
    u_qdf_host_model.send(c, n);
    repeat (20) @(posedge core_clk_i);
    #1;
    if (n == 24 && !rd && sel == 3'h0)
      for (int k = 0; k < 4; k++)
        if (addr == 3'h4 || addr == k[2:0])
          exp_code[k] = trim(data, res_i);
    if (n == 24 && rd) exp_rd++;
    if (n == 24 && !rd && sel != 3'h0) exp_wr++;
    exp_all = {exp_code[3], exp_code[2], exp_code[1], exp_code[0]};
    check(code_o, exp_all);
    check(64'(wr_cnt), 64'(exp_wr));
    check(64'(rd_cnt), 64'(exp_rd));
    if (n == 24 && rd && sel == 3'h0 && addr < 3'h4)
      check(rd_data_o, exp_code[addr[1:0]]);
    if (n == 24 && !rd && sel != 3'h0)
      check({other_sel_o, other_addr_o, other_data_o}, c[21:0]);
  endtask : cmd

  // hang guard
  initial begin
    #400000;
    err_count++;
    conclude();
  end

  initial begin
    for (int k = 0; k < 4; k++) exp_code[k] = 16'h0000;
    // reset leaves x late, so link-side async clears see an edge
    #1 rst_n_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    check(code_o, 64'h0);
    check(zero_err_o, 1'b0);
    // every address code, undefined ones too, each under a random variant
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      res_i = (r[25:24] == 2'h3) ? 2'h1 : r[25:24];
      cmd(1'b0, 1'b0, 3'h0, k[2:0], r[15:0], 24);
    end
    $display("test address codes done");
    for (int k = 0; k < 20; k++) begin
      r = $random(seed);
      res_i = (r[25:24] == 2'h3) ? 2'h2 : r[25:24];
      cmd(r[31], 1'b0, r[30:28] & 3'h3, r[27:25], r[15:0], 24);
    end
    $display("test random traffic done");
    for (int s = 1; s < 4; s++)
      cmd(1'b0, 1'b0, s[2:0], 3'h1, 16'ha5c3, 24);
    for (int ch = 0; ch < 4; ch++)
      cmd(1'b1, 1'b0, 3'h0, ch[2:0], 16'h0, 24);
    $display("test selects and reads done");
    cmd(1'b0, 1'b0, 3'h0, 3'h4, 16'hffff, 23);
    $display("test short frame done");
    cmd(1'b0, 1'b1, 3'h0, 3'h2, 16'h1234, 24);
    check(zero_err_o, 1'b1);
    $display("test reserved bit done");
    conclude();
  end
endmodule : testbench
